// >>> hdl/psr_defines.svh
`ifndef PSR_DEFINES_SVH
`define PSR_DEFINES_SVH

// register address space of the serial control port
`define PSR_ADDR_W 10
`define PSR_DATA_W 8

// status readback register
`define PSR_STATUS_ADDR 10'h01f

// field positions inside the status byte
`define PSR_BIT_LOCK 0
`define PSR_BIT_FIRST_FAST 1
`define PSR_BIT_SECOND_FAST 2
`define PSR_BIT_OSC_FAST 3
`define PSR_BIT_SECOND_SEL 4
`define PSR_BIT_HOLDOVER 5

// number of live status lines
`define PSR_NUM_STATUS 6

// reset and idle values
`define PSR_RESET_BYTE 8'h00
`define PSR_STATUS_RESET 6'h00

// cycles from a status pin change to its visibility in the register
`define PSR_SYNC_DELAY 2

`endif

// >>> hdl/psr_pkg.sv
`include "psr_defines.svh"

package psr_pkg;
   typedef logic [`PSR_ADDR_W-1:0] psr_addr_t;
   typedef logic [`PSR_DATA_W-1:0] psr_byte_t;
   typedef logic [`PSR_NUM_STATUS-1:0] psr_status_t;
endpackage : psr_pkg

// >>> hdl/psr_sync.sv
`timescale 1ns/10ps
`default_nettype none
`include "psr_defines.svh"

module psr_sync
   import psr_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire psr_pkg::psr_status_t async_i,
   output logic [`PSR_NUM_STATUS-1:0] sync_o
);
   import psr_pkg::*;

   psr_status_t meta;
   psr_status_t stable;
   psr_status_t next_meta;
   psr_status_t next_stable;

   // first stage is read only by the second stage
   always_comb begin
      next_meta = async_i;
      next_stable = meta;
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         meta <= `PSR_STATUS_RESET;
         stable <= `PSR_STATUS_RESET;
      end else begin
         meta <= next_meta;
         stable <= next_stable;
      end
   end

   assign sync_o = stable;

endmodule : psr_sync
`default_nettype wire

// >>> hdl/psr_status_reg.sv
// Function
// RL1 - status bit 5 at 0x01f reads 1 while the loop sits in holdover
// RL2 - holdover bit follows live holdover state, not the holdover enable setting
// RL3 - bit 4 reads 1 when second reference drives the loop, else 0
// RL4 - bit 3 reads 1 when oscillator frequency is above its threshold
// RL5 - bit 2 reads 1 when second reference frequency exceeds configured threshold
// RL6 - bit 1 reads 1 when first reference frequency exceeds configured threshold
// RL7 - bit 0 presents digital lock detect, 1 when locked
// RL8 - writes leave the status register unchanged; reads return current status
`timescale 1ns/10ps
`default_nettype none
`include "psr_defines.svh"

module psr_status_reg
   import psr_pkg::*;
(
   // register port of the serial control logic
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire psr_pkg::psr_addr_t reg_addr_i,
   input wire logic reg_rd_i,
   input wire logic reg_wr_i,
   input wire psr_pkg::psr_byte_t reg_wdata_i,
   output psr_pkg::psr_byte_t reg_rdata_o,
   output logic reg_rvalid_o,
   output logic reg_hit_o,
   // live status from the loop monitors, any clock domain
   input wire logic holdover_active_i,
   input wire logic second_reference_input_sel_i,
   input wire logic pll_oscillator_above_i,
   input wire logic second_reference_input_above_i,
   input wire logic first_reference_input_above_i,
   input wire logic digital_lock_i
);
   import psr_pkg::*;

   // status path, pins to byte
   psr_status_t raw_status;
   psr_status_t live_status;
   psr_byte_t status_byte;

   // read answer registers
   psr_byte_t rdata;
   psr_byte_t next_rdata;
   logic rvalid;
   logic next_rvalid;

   // address decode and the unused write data
   logic addr_hit;
   logic wdata_unused;

   // decode of the single mapped address
   function automatic logic psr_is_status(input psr_addr_t addr);
      psr_is_status = (addr == `PSR_STATUS_ADDR);
   endfunction : psr_is_status

   // gather status lines; they come from other clock or analog domains
   // no filtering: a pulse shorter than one clock may be missed
   always_comb begin
      raw_status = `PSR_STATUS_RESET;
      raw_status[`PSR_BIT_HOLDOVER] = holdover_active_i; // [RL1] [RL2]
      raw_status[`PSR_BIT_SECOND_SEL] = second_reference_input_sel_i; // [RL3]
      raw_status[`PSR_BIT_OSC_FAST] = pll_oscillator_above_i; // [RL4]
      raw_status[`PSR_BIT_SECOND_FAST] = second_reference_input_above_i; // [RL5]
      raw_status[`PSR_BIT_FIRST_FAST] = first_reference_input_above_i; // [RL6]
      raw_status[`PSR_BIT_LOCK] = digital_lock_i; // [RL7]
   end

   // two flops per line; a pin edge reaches the byte on the second clock
   psr_sync u_sync (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .async_i(raw_status),
      .sync_o(live_status)
   );

   // bits 7 and 6 read zero: calibration flag lives elsewhere
   assign status_byte = {2'h0, live_status};
   assign addr_hit = psr_is_status(reg_addr_i);
   // write data has no home here, the register is read only
   assign wdata_unused = ^reg_wdata_i; // [RL8]

   // read answer one cycle after the strobe; unmapped reads give zero
   // a read beside a write is served; the write is dropped
   always_comb begin
      next_rdata = rdata;
      next_rvalid = 1'b0;
      if (reg_rd_i) begin
         next_rvalid = 1'b1;
         next_rdata = addr_hit ? status_byte : `PSR_RESET_BYTE; // [RL8]
      end
   end

   // answer registers; reset leaves a zero byte and no answer
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rdata <= `PSR_RESET_BYTE;
         rvalid <= 1'b0;
      end else begin
         rdata <= next_rdata;
         rvalid <= next_rvalid;
      end
   end

   // outputs: data from flops, hit straight from the decode
   assign reg_rdata_o = rdata;
   assign reg_rvalid_o = rvalid;
   assign reg_hit_o = addr_hit & (reg_rd_i | reg_wr_i);

   // helper: sync pipeline is primed after this many edges
   logic [1:0] warm;
   logic [1:0] next_warm;
   logic primed;
   assign primed = (warm == 2'(`PSR_SYNC_DELAY + 1));

   // count up to one past the sync depth, then hold
   always_comb begin
      next_warm = primed ? warm : 2'(warm + 2'h1);
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         warm <= 2'h0;
      end else begin
         warm <= next_warm;
      end
   end

   // checks run on the port clock and rest while reset is low
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   // live fields trail their pins by the two sync edges
   holdover_bit_a: assert property (primed |-> // [RL1]
      status_byte[`PSR_BIT_HOLDOVER] == $past(holdover_active_i, 2))
      else $error("holdover bit does not follow holdover state");
   second_sel_bit_a: assert property (primed |-> // [RL3]
      status_byte[`PSR_BIT_SECOND_SEL] == $past(second_reference_input_sel_i, 2))
      else $error("reference select bit wrong");
   osc_thresh_a: assert property (primed |-> // [RL4]
      status_byte[`PSR_BIT_OSC_FAST] == $past(pll_oscillator_above_i, 2))
      else $error("oscillator threshold bit wrong");
   second_thresh_a: assert property (primed |-> // [RL5]
      status_byte[`PSR_BIT_SECOND_FAST] == $past(second_reference_input_above_i, 2))
      else $error("second reference threshold bit wrong");
   first_thresh_a: assert property (primed |-> // [RL6]
      status_byte[`PSR_BIT_FIRST_FAST] == $past(first_reference_input_above_i, 2))
      else $error("first reference threshold bit wrong");
   lock_bit_a: assert property (primed |-> // [RL7]
      status_byte[`PSR_BIT_LOCK] == $past(digital_lock_i, 2))
      else $error("lock detect bit does not follow lock state");
   sync_pipe_a: assert property (primed |-> // [RL2]
      live_status == $past(raw_status, 2))
      else $error("status pipeline lost a line");

   // each field as read back, one edge later for the answer register
   holdover_read_a: assert property ((primed && reg_rd_i && addr_hit) |=> // [RL2]
      reg_rdata_o[`PSR_BIT_HOLDOVER] == $past(holdover_active_i, 3))
      else $error("holdover readback wrong");
   second_sel_read_a: assert property ((primed && reg_rd_i && addr_hit) |=> // [RL3]
      reg_rdata_o[`PSR_BIT_SECOND_SEL] == $past(second_reference_input_sel_i, 3))
      else $error("reference select readback wrong");
   osc_read_a: assert property ((primed && reg_rd_i && addr_hit) |=> // [RL4]
      reg_rdata_o[`PSR_BIT_OSC_FAST] == $past(pll_oscillator_above_i, 3))
      else $error("oscillator threshold readback wrong");
   second_thresh_read_a: assert property ((primed && reg_rd_i && addr_hit) |=> // [RL5]
      reg_rdata_o[`PSR_BIT_SECOND_FAST] == $past(second_reference_input_above_i, 3))
      else $error("second reference threshold readback wrong");
   first_thresh_read_a: assert property ((primed && reg_rd_i && addr_hit) |=> // [RL6]
      reg_rdata_o[`PSR_BIT_FIRST_FAST] == $past(first_reference_input_above_i, 3))
      else $error("first reference threshold readback wrong");
   lock_read_a: assert property ((primed && reg_rd_i && addr_hit) |=> // [RL7]
      reg_rvalid_o && reg_rdata_o[`PSR_BIT_LOCK] == $past(digital_lock_i, 3))
      else $error("lock detect readback wrong");

   // answer handshake: one pulse per strobe, data held between reads
   rvalid_pulse_a: assert property (reg_rd_i |=> // [RL8]
      reg_rvalid_o)
      else $error("read strobe got no answer");
   rvalid_quiet_a: assert property (!reg_rd_i |=> // [RL8]
      !reg_rvalid_o)
      else $error("answer without a read strobe");
   rdata_hold_a: assert property (!reg_rd_i |=> // [RL8]
      $stable(reg_rdata_o))
      else $error("read data moved without a read");
   mapped_read_a: assert property ((reg_rd_i && addr_hit) |=> // [RL8]
      reg_rdata_o == $past(status_byte))
      else $error("status read did not return current status");
   back_to_back_a: assert property ((reg_rd_i ##1 reg_rd_i) |=> // [RL8]
      reg_rvalid_o)
      else $error("second of two reads got no answer");

   // writes have no effect, alone or beside a read
   write_ignored_a: assert property ((reg_wr_i && !reg_rd_i) |=> // [RL8]
      !reg_rvalid_o && $stable(reg_rdata_o))
      else $error("write disturbed readback");
   read_beats_write_a: assert property ((reg_rd_i && reg_wr_i && addr_hit) |=> // [RL8]
      reg_rvalid_o && reg_rdata_o == $past(status_byte))
      else $error("read beside a write not served");

   // unmapped addresses and unused bits read zero
   unmapped_zero_a: assert property ((reg_rd_i && !addr_hit) |=> // [RL8]
      reg_rvalid_o && reg_rdata_o == `PSR_RESET_BYTE)
      else $error("unmapped read not zero");
   upper_zero_a: assert property (reg_rvalid_o |->
      reg_rdata_o[7:6] == 2'h0)
      else $error("upper bits not zero");

   // hit flag needs the mapped address and a strobe
   hit_on_read_a: assert property ((reg_rd_i && reg_addr_i == `PSR_STATUS_ADDR) |->
      reg_hit_o)
      else $error("read of the status address not flagged");
   hit_on_write_a: assert property ((reg_wr_i && reg_addr_i == `PSR_STATUS_ADDR) |->
      reg_hit_o)
      else $error("write to the status address not flagged");
   hit_miss_a: assert property ((reg_addr_i != `PSR_STATUS_ADDR) |->
      !reg_hit_o)
      else $error("hit flagged for another address");
   hit_idle_a: assert property ((!reg_rd_i && !reg_wr_i) |->
      !reg_hit_o)
      else $error("hit flagged without a strobe");

endmodule : psr_status_reg
`default_nettype wire

// >>> tb/psr_status_reg_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "psr_defines.svh"

module psr_status_reg_tb_top;
   import psr_pkg::*;
   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   psr_addr_t addr = '0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   psr_byte_t wdata = 8'h00;
   psr_byte_t rdata;
   logic rvalid;
   logic hit;
   psr_status_t st = '0;
   int err_count = 0;
   int num_checks = 0;

   psr_status_reg psr_status_reg_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
      .reg_addr_i(addr), .reg_rd_i(rd), .reg_wr_i(wr), .reg_wdata_i(wdata),
      .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .reg_hit_o(hit),
      .holdover_active_i(st[5]), .second_reference_input_sel_i(st[4]),
      .pll_oscillator_above_i(st[3]), .second_reference_input_above_i(st[2]),
      .first_reference_input_above_i(st[1]), .digital_lock_i(st[0]));

   // 4 ns period
   initial begin
      forever #2 clk_i = ~clk_i;
   end

   task automatic check(input string name, input psr_byte_t seen, input psr_byte_t exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic report_and_stop;
      if (err_count == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : report_and_stop

   // status pins need three edges to reach the readback
   task automatic set_status(input psr_status_t v);
      @(posedge clk_i);
      st <= v;
      repeat (3) @(posedge clk_i);
   endtask : set_status

   // one read strobe, optionally with a write in the same cycle
   task automatic read_chk(input psr_addr_t a, input logic w, input psr_byte_t exp);
      @(posedge clk_i);
      addr <= a;
      rd <= 1'b1;
      wr <= w;
      wdata <= 8'hff;
      #1 check("hit", {7'h00, hit}, {7'h00, a == `PSR_STATUS_ADDR});
      @(posedge clk_i);
      rd <= 1'b0;
      wr <= 1'b0;
      #1 check("rvalid", {7'h00, rvalid}, 8'h01);
      check("rdata", rdata, exp);
   endtask : read_chk

   // walk a single one over every status line
   task automatic walk_bits;
      for (int i = 0; i < 6; i++) begin
         set_status(psr_status_t'(6'h01 << i));
         read_chk(`PSR_STATUS_ADDR, 1'b0, 8'h01 << i);
      end
      set_status(6'h3f);
      read_chk(`PSR_STATUS_ADDR, 1'b0, 8'h3f);
   endtask : walk_bits

   // a lone write must not answer or change the byte
   task automatic write_ignored;
      set_status(6'h2a);
      read_chk(`PSR_STATUS_ADDR, 1'b0, 8'h2a);
      @(posedge clk_i);
      addr <= `PSR_STATUS_ADDR;
      wr <= 1'b1;
      #1 check("wr_hit", {7'h00, hit}, 8'h01);
      @(posedge clk_i);
      wr <= 1'b0;
      #1 check("wr_rvalid", {7'h00, rvalid}, 8'h00);
      check("wr_rdata", rdata, 8'h2a);
      read_chk(`PSR_STATUS_ADDR, 1'b1, 8'h2a);
      set_status(6'h15);
      read_chk(`PSR_STATUS_ADDR, 1'b0, 8'h15);
      read_chk(10'h01e, 1'b0, 8'h00);
   endtask : write_ignored

   // back-to-back reads, one answer per cycle
   task automatic back_to_back;
      set_status(6'h33);
      @(posedge clk_i);
      addr <= `PSR_STATUS_ADDR;
      rd <= 1'b1;
      @(posedge clk_i);
      addr <= 10'h01e;
      #1 check("b2b_rvalid0", {7'h00, rvalid}, 8'h01);
      check("b2b_rdata0", rdata, 8'h33);
      @(posedge clk_i);
      rd <= 1'b0;
      #1 check("b2b_rvalid1", {7'h00, rvalid}, 8'h01);
      check("b2b_rdata1", rdata, 8'h00);
   endtask : back_to_back

   // reset in mid-run clears the answer, then status comes back
   task automatic reset_mid_run;
      set_status(6'h3f);
      read_chk(`PSR_STATUS_ADDR, 1'b0, 8'h3f);
      @(posedge clk_i);
      reset_n_i <= 1'b0;
      addr <= `PSR_STATUS_ADDR;
      rd <= 1'b1;
      @(posedge clk_i);
      #1 check("rst_rvalid", {7'h00, rvalid}, 8'h00);
      check("rst_rdata", rdata, 8'h00);
      @(posedge clk_i);
      rd <= 1'b0;
      reset_n_i <= 1'b1;
      repeat (`PSR_SYNC_DELAY) @(posedge clk_i);
      read_chk(`PSR_STATUS_ADDR, 1'b0, 8'h3f);
   endtask : reset_mid_run

   // cut a hang short
   initial begin
      repeat (5000) @(posedge clk_i);
      err_count++;
      report_and_stop();
   end

   initial begin
      repeat (20) @(posedge clk_i);
      reset_n_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      read_chk(`PSR_STATUS_ADDR, 1'b0, 8'h00);
      walk_bits();
      write_ignored();
      back_to_back();
      reset_mid_run();
      report_and_stop();
   end
endmodule : psr_status_reg_tb_top

`default_nettype wire
